/* File: hw/servo_request_pkg.sv */
// Purpose: Constants and types for the servo request contact bank.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: All offsets are byte addresses.
//
// Summary of operation
// [R01] A warning-clear request asks every connected amplifier to clear its warnings at once.
// [R02] A warning-clear request also erases the stored warning log.
// [R03] The controller raises the recalculation request whenever it changes positioning data.
// [R04] A recalculation request rebuilds all positioning data from the start table number onward.
// [R05] When the rebuild is finished the recalculation done flag is set.
// [R06] The controller uses the recalculation request only after rewriting positioning data.
// [R07] Each axis servo-on request asks that axis's amplifier for servo lock.
// [R08] Servo lock is started only by the rising edge of the servo-on request.
// [R09] Entering program edit mode does not release a locked axis.
// [R10] The controller releases a locked axis by raising its servo-off request.
// [R11] The error-clear request never recovers an unrecoverable error.
// [R12] An error-clear request runs recovery on all amplifiers and clears the error log.
// [R13] Servo free for an axis is started by the rising edge of its servo-off request.
// [R14] There are eight servo-on request bits; axes seven and eight are virtual.
package servo_request_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REQ_OFS      = 8'h00;
   localparam logic [7:0] SERVO_ON_OFS = 8'h04;
   localparam logic [7:0] SERVO_OFF_OFS= 8'h08;
   localparam logic [7:0] STATUS_OFS   = 8'h0C;
   localparam logic [7:0] START_OFS    = 8'h10;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
   localparam logic [7:0] IRQ_CLR_OFS  = 8'h18;
   localparam logic [7:0] IRQ_EN_OFS   = 8'h1C;
   // ----------------------------------------------------------------
   // Field positions and sizes
   // ----------------------------------------------------------------
   localparam int ERR_CLR_BIT  = 0;
   localparam int WARN_CLR_BIT = 1;
   localparam int RECALC_BIT   = 2;
   localparam int NUM_AXES     = 8;
   localparam int PHYS_AXES    = 6;
   localparam int IRQ_BITS     = 4;
   localparam logic [7:0] PHYS_MASK = 8'h3F;
   localparam logic [15:0] START_RESET = 16'h0000;
   localparam logic [15:0] RECALC_CYCLES_PER_TABLE = 16'h0001;
   typedef enum logic [1:0] {RC_IDLE, RC_BUSY} recalc_e;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic [7:0] lockReq;
      logic [7:0] freeReq;
      logic       warnClear;
      logic       errRecover;
   } amp_cmd_s;
endpackage

/* File: hw/servo_request_contacts.sv */
// Purpose: Output-contact request bank of a positioning unit.
// Assumes: Single clock ref_clk at 50 MHz, asynchronous active-high reset.
// Notes: Amplifier commands are one-cycle pulses.
module servo_request_contacts
   import servo_request_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // APB slave
   input  wire apb_req_s    apbReq,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Unit state
   input  wire logic        program_edit_mode,
   input  wire logic [7:0]  errUnrecoverable,
   input  wire logic [15:0] tableCount,
   // Amplifier side
   output amp_cmd_s         ampCmd,
   output logic [7:0]       lockState,
   output logic             warnLogClear,
   output logic             errLogClear,
   output logic [15:0]      rebuildTable,
   output logic             rebuildActive,
   output logic             recalculation_done_flag,
   output logic             irq
);
   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Compares a bus address with one register offset.
   function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   // Marks bits that are high now and were low one cycle earlier.
   function automatic logic [7:0] riseOf(input logic [7:0] now, input logic [7:0] prev);
      return now & ~prev;
   endfunction

   // Steps the rebuild pointer to the following table.
   function automatic logic [15:0] nextTable(input logic [15:0] tbl);
      return tbl + RECALC_CYCLES_PER_TABLE;
   endfunction

   // True on the last table; the extra bit keeps the pointer from wrapping at the top.
   function automatic logic lastTable(input logic [15:0] tbl, input logic [15:0] count);
      return ({1'b0, tbl} + {1'b0, RECALC_CYCLES_PER_TABLE}) >= {1'b0, count};
   endfunction

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // The slave never stretches a transfer, so every access lasts one cycle.
   wire busAccess = apbReq.psel & apbReq.penable;
   wire wrEn      = busAccess & apbReq.pwrite;
   wire rdSetup   = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
   wire selReq    = addrHit(apbReq.paddr, REQ_OFS);
   wire selOn     = addrHit(apbReq.paddr, SERVO_ON_OFS);
   wire selOff    = addrHit(apbReq.paddr, SERVO_OFF_OFS);
   wire selSt     = addrHit(apbReq.paddr, STATUS_OFS);
   wire selTb     = addrHit(apbReq.paddr, START_OFS);
   wire selIs     = addrHit(apbReq.paddr, IRQ_STAT_OFS);
   wire selIc     = addrHit(apbReq.paddr, IRQ_CLR_OFS);
   wire selIe     = addrHit(apbReq.paddr, IRQ_EN_OFS);
   wire mapped    = selReq | selOn | selOff | selSt | selTb | selIs | selIc | selIe;
   wire wrReq     = wrEn & selReq;
   wire wrOn      = wrEn & selOn;
   wire wrOff     = wrEn & selOff;
   wire wrTb      = wrEn & selTb;
   wire wrIc      = wrEn & selIc;
   wire wrIe      = wrEn & selIe;
   assign pready  = 1'b1;
   assign pslverr = busAccess & ~mapped;

   // ----------------------------------------------------------------
   // Request contact registers
   // ----------------------------------------------------------------
   logic [2:0]  reqBits_q;
   logic [2:0]  reqBits_d;
   logic [7:0]  servoOn_q;
   logic [7:0]  servoOn_d;
   logic [7:0]  servoOff_q;
   logic [7:0]  servoOff_d;
   logic [15:0] startTable_q;
   logic [15:0] startTable_d;

   assign reqBits_d    = wrReq ? apbReq.pwdata[2:0] : reqBits_q;
   assign servoOn_d    = wrOn ? apbReq.pwdata[7:0] : servoOn_q; // R14
   assign servoOff_d   = wrOff ? apbReq.pwdata[7:0] : servoOff_q;
   assign startTable_d = wrTb ? apbReq.pwdata[15:0] : startTable_q;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reqBits_q <= 3'h0;
      end else begin
         reqBits_q <= reqBits_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         servoOn_q <= 8'h00;
      end else begin
         servoOn_q <= servoOn_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         servoOff_q <= 8'h00;
      end else begin
         servoOff_q <= servoOff_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         startTable_q <= START_RESET;
      end else begin
         startTable_q <= startTable_d;
      end
   end

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   logic [2:0] reqPrev_q;
   logic [7:0] onPrev_q;
   logic [7:0] offPrev_q;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reqPrev_q <= 3'h0;
         onPrev_q  <= 8'h00;
         offPrev_q <= 8'h00;
      end else begin
         reqPrev_q <= reqBits_q;
         onPrev_q  <= servoOn_q;
         offPrev_q <= servoOff_q;
      end
   end

   wire [2:0] reqRise     = reqBits_q & ~reqPrev_q;
   wire [7:0] onRise      = riseOf(servoOn_q, onPrev_q);   // R08
   wire [7:0] offRise     = riseOf(servoOff_q, offPrev_q); // R13
   wire [7:0] lockGrant   = onRise & ~offRise;             // R07
   wire       warnPulse   = reqRise[WARN_CLR_BIT];
   wire       errPulse    = reqRise[ERR_CLR_BIT];
   wire       recalcPulse = reqRise[RECALC_BIT];

   // ----------------------------------------------------------------
   // Lock state and amplifier commands
   // ----------------------------------------------------------------
   logic [7:0] lock_q;
   logic [7:0] lock_d;
   amp_cmd_s   cmd_q;
   amp_cmd_s   cmd_d;
   logic       warnLog_q;
   logic       errLog_q;

   // Lock follows edges only; an off edge wins over an on edge in the same cycle.
   assign lock_d = (lock_q | onRise) & ~offRise; // R07 R09 R10
   assign cmd_d  = '{lockReq: lockGrant, freeReq: offRise, warnClear: warnPulse, errRecover: errPulse}; // R01 R12 R13

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         lock_q <= 8'h00;
      end else begin
         lock_q <= lock_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cmd_q <= '0;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         warnLog_q <= 1'b0;
      end else begin
         warnLog_q <= warnPulse; // R02
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         errLog_q <= 1'b0;
      end else begin
         errLog_q <= errPulse; // R12
      end
   end

   assign ampCmd       = cmd_q;
   assign lockState    = lock_q;
   assign warnLogClear = warnLog_q;
   assign errLogClear  = errLog_q;

   // ----------------------------------------------------------------
   // Unrecoverable error report
   // ----------------------------------------------------------------
   // Unrecoverable axes are only reported; the amplifier keeps them in error.
   logic [7:0] errSticky_q;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         errSticky_q <= 8'h00;
      end else begin
         errSticky_q <= errUnrecoverable; // R11
      end
   end

   // ----------------------------------------------------------------
   // Recalculation sequencer
   // ----------------------------------------------------------------
   // One table is rebuilt per clock; done stays set until the next request.
   recalc_e     state_q;
   recalc_e     state_d;
   logic [15:0] tbl_q;
   logic [15:0] tbl_d;
   logic        done_q;
   logic        done_d;
   wire         atLast = lastTable(tbl_q, tableCount);

   always_comb begin
      state_d = state_q;
      tbl_d   = tbl_q;
      done_d  = done_q;
      case (state_q)
         RC_IDLE: begin
            if (recalcPulse) begin
               state_d = RC_BUSY; // R04
               tbl_d   = startTable_q;
               done_d  = 1'b0;
            end
         end
         RC_BUSY: begin
            if (atLast) begin
               state_d = RC_IDLE;
               done_d  = 1'b1; // R05
            end else begin
               tbl_d = nextTable(tbl_q); // R04
            end
         end
         default: begin
            state_d = RC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= RC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tbl_q <= START_RESET;
      end else begin
         tbl_q <= tbl_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         done_q <= 1'b0;
      end else begin
         done_q <= done_d;
      end
   end

   assign rebuildTable            = tbl_q;
   assign rebuildActive           = state_q == RC_BUSY;
   assign recalculation_done_flag = done_q;
   wire   recalcDoneEv            = rebuildActive & atLast;

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   logic [IRQ_BITS-1:0] irqStat_q;
   logic [IRQ_BITS-1:0] irqStat_d;
   logic [IRQ_BITS-1:0] irqEn_q;
   logic [IRQ_BITS-1:0] irqEn_d;
   wire  [IRQ_BITS-1:0] irqEv  = {|offRise, |lockGrant, warnPulse, recalcDoneEv};
   wire  [IRQ_BITS-1:0] irqClr = wrIc ? apbReq.pwdata[IRQ_BITS-1:0] : '0;
   // Set wins: an event in the cycle of its clear leaves the bit set.
   assign irqStat_d = (irqStat_q & ~irqClr) | irqEv;
   assign irqEn_d   = wrIe ? apbReq.pwdata[IRQ_BITS-1:0] : irqEn_q;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irqStat_q <= '0;
      end else begin
         irqStat_q <= irqStat_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irqEn_q <= '0;
      end else begin
         irqEn_q <= irqEn_d;
      end
   end

   assign irq = |(irqStat_q & irqEn_q);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Read data is captured in the setup cycle so it stands through the access phase.
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   wire  [31:0] status = {6'h00, errSticky_q, program_edit_mode, rebuildActive, done_q, 7'h00, lock_q};
   wire  [31:0] rdMux =
      selReq ? {29'h0, reqBits_q} :
      selOn  ? {24'h0, servoOn_q} :
      selOff ? {24'h0, servoOff_q} :
      selSt  ? status :
      selTb  ? {16'h0, startTable_q} :
      selIs  ? {28'h0, irqStat_q} :
      selIe  ? {28'h0, irqEn_q} : 32'h0;
   assign rdData_d = rdSetup ? rdMux : rdData_q;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdData_q <= 32'h0;
      end else begin
         rdData_q <= rdData_d;
      end
   end

   assign prdata = rdData_q;
endmodule // servo_request_contacts

/* File: verification/servo_request_props.sv */
// Purpose: Port checker for the servo request contact bank.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes: Bound to every instance of the design top.
module servo_request_props
   import servo_request_pkg::*;
(
   // Clock, reset and bus
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire apb_req_s    apbReq,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Unit state and amplifier side
   input wire logic        program_edit_mode,
   input wire logic [7:0]  errUnrecoverable,
   input wire logic [15:0] tableCount,
   input wire amp_cmd_s    ampCmd,
   input wire logic [7:0]  lockState,
   input wire logic        warnLogClear,
   input wire logic        errLogClear,
   input wire logic [15:0] rebuildTable,
   input wire logic        rebuildActive,
   input wire logic        recalculation_done_flag,
   input wire logic        irq
);
   wire unmapped = apbReq.psel & apbReq.penable & ((apbReq.paddr[7:5] != 3'h0) | (apbReq.paddr[1:0] != 2'h0));
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_slverr; pslverr == unmapped; endproperty
   a_slverr: assert property (p_slverr) else $error("pslverr wrong");
   property p_lock_pulse; (ampCmd.lockReq & $past(ampCmd.lockReq)) == 8'h00; endproperty
   a_lock_pulse: assert property (p_lock_pulse) else $error("lock request held");
   property p_lock_set; (lockState & ~$past(lockState) & ~ampCmd.lockReq & ~$past(ampCmd.lockReq)) == 8'h00; endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock without request");
   property p_lock_hold; (~lockState & $past(lockState) & ~ampCmd.freeReq & ~$past(ampCmd.freeReq)) == 8'h00; endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock lost without free");
   property p_disjoint; (ampCmd.lockReq & ampCmd.freeReq) == 8'h00; endproperty
   a_disjoint: assert property (p_disjoint) else $error("lock and free together");
   property p_warn; ampCmd.warnClear == warnLogClear; endproperty
   a_warn: assert property (p_warn) else $error("warning clear split");
   property p_err; ampCmd.errRecover == errLogClear; endproperty
   a_err: assert property (p_err) else $error("error clear split");
   property p_done; $rose(recalculation_done_flag) |-> $past(rebuildActive); endproperty
   a_done: assert property (p_done) else $error("done without rebuild");
   c_lock: cover property (ampCmd.lockReq != 8'h00);
   c_free: cover property (ampCmd.freeReq != 8'h00);
   c_rebuild: cover property ($fell(rebuildActive));
   c_irq: cover property (irq);
endmodule // servo_request_props
bind servo_request_contacts servo_request_props props_u (.ref_clk(ref_clk), .reset(reset), .apbReq(apbReq),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .program_edit_mode(program_edit_mode),
   .errUnrecoverable(errUnrecoverable), .tableCount(tableCount), .ampCmd(ampCmd), .lockState(lockState),
   .warnLogClear(warnLogClear), .errLogClear(errLogClear), .rebuildTable(rebuildTable),
   .rebuildActive(rebuildActive), .recalculation_done_flag(recalculation_done_flag), .irq(irq));

/* File: verification/servo_cpu_model.sv */
// Purpose: Controller model that drives request contacts over APB.
// Assumes: Tasks are called from the bench after a clock edge.
// Notes: Released write data is inverted so stale values never look valid.
module servo_cpu_model
   import servo_request_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output apb_req_s         apbReq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hung = 1'b0;
   initial apbReq = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge ref_clk);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge ref_clk);
      apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      q = prdata;
      hung = (n >= 64);
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      apbReq.pwdata <= ~d;
   endtask
   // Requests act on rising edges, so each one is written high and then low.
   task automatic pulse(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
      xfer(1'b1, a, 32'h0, q);
   endtask
endmodule // servo_cpu_model

/* File: verification/servo_request_contacts_tb_top.sv */
// Purpose: Self-checking bench for the servo request contact bank.
// Assumes: Zero-wait APB slave, one table rebuilt per cycle.
// Notes: Expectations are tracked in bench variables.
module servo_request_contacts_tb_top import servo_request_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, reset = 1'b1, pem = 1'b0;
   logic [7:0] errU = 8'h00, lk = 8'h00, lockState;
   logic [15:0] tabs = 16'h0005, rt;
   logic [31:0] prdata, q, s = 32'hF1E45F86;
   logic pready, pslverr, done, act, irq, wlc, elc;
   logic slvErr = 1'b0;
   apb_req_s apbReq;
   amp_cmd_s cmd;
   int error_cnt = 0, total_checks = 0, wn = 0, en = 0, ac = 0, n;
   always #10 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      wn += int'(wlc);
      en += int'(elc);
      ac += int'(act);
   end
   always @(posedge ref_clk) if (apbReq.psel && apbReq.penable) slvErr <= pslverr;
   always @(posedge cpu_u.hung) begin
      error_cnt++;
      final_report();
   end
   servo_request_contacts dut_u (.ref_clk(ref_clk), .reset(reset), .apbReq(apbReq), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .program_edit_mode(pem), .errUnrecoverable(errU), .tableCount(tabs),
      .ampCmd(cmd), .lockState(lockState), .warnLogClear(wlc), .errLogClear(elc), .rebuildTable(rt),
      .rebuildActive(act), .recalculation_done_flag(done), .irq(irq));
   servo_cpu_model cpu_u (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .apbReq(apbReq));
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      cpu_u.xfer(1'b0, STATUS_OFS, 32'h0, q);
      chk("status", q, 32'h0);
      #1 chk("slverr mapped", {31'h0, slvErr}, 32'h0);
      cpu_u.xfer(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", q, 32'h0);
      #1 chk("slverr", {31'h0, slvErr}, 32'h1);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         q = rnd();
         if (i == 0) q[7:6] = 2'b11;
         @(posedge ref_clk) pem <= q[8];
         cpu_u.pulse(SERVO_ON_OFS, {24'h0, q[7:0]});
         lk = lk | q[7:0];
         repeat (3) @(posedge ref_clk);
         #1 chk("lock", {24'h0, lockState}, {24'h0, lk});
         q = rnd();
         cpu_u.pulse(SERVO_OFF_OFS, {24'h0, q[7:0]});
         lk = lk & ~q[7:0];
         repeat (3) @(posedge ref_clk);
         #1 chk("free", {24'h0, lockState}, {24'h0, lk});
      end
      cpu_u.pulse(SERVO_OFF_OFS, 32'hFF);
      cpu_u.xfer(1'b1, SERVO_ON_OFS, 32'h81, q);
      cpu_u.pulse(SERVO_OFF_OFS, 32'hFF);
      cpu_u.xfer(1'b1, SERVO_ON_OFS, 32'h81, q);
      repeat (3) @(posedge ref_clk);
      #1 chk("level", {24'h0, lockState}, 32'h0);
      cpu_u.xfer(1'b1, SERVO_ON_OFS, 32'h0, q);
      $display("test servo done");
      cpu_u.xfer(1'b1, IRQ_EN_OFS, 32'h0, q);
      cpu_u.xfer(1'b1, IRQ_CLR_OFS, 32'hF, q);
      cpu_u.pulse(REQ_OFS, 32'h1 << WARN_CLR_BIT);
      repeat (2) @(posedge ref_clk);
      #1 chk("masked", {31'h0, irq}, 32'h0);
      chk("warn", 32'(wn), 32'h1);
      cpu_u.xfer(1'b1, IRQ_EN_OFS, 32'h2, q);
      #1 chk("irq", {31'h0, irq}, 32'h1);
      cpu_u.xfer(1'b1, IRQ_CLR_OFS, 32'h2, q);
      #1 chk("cleared", {31'h0, irq}, 32'h0);
      $display("test warning done");
      q = rnd();
      @(posedge ref_clk) errU <= q[7:0];
      cpu_u.pulse(REQ_OFS, 32'h1 << ERR_CLR_BIT);
      repeat (2) @(posedge ref_clk);
      #1 chk("recover", 32'(en), 32'h1);
      cpu_u.xfer(1'b0, STATUS_OFS, 32'h0, q);
      chk("unrec", {24'h0, q[25:18]}, {24'h0, errU});
      $display("test error done");
      @(posedge ref_clk) tabs <= 16'h0008;
      cpu_u.xfer(1'b1, START_OFS, 32'h3, q);
      cpu_u.pulse(REQ_OFS, 32'h1 << RECALC_BIT);
      for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge ref_clk);
      #1 chk("done", {31'h0, done}, 32'h1);
      if (n >= 40) final_report();
      chk("tables", 32'(ac), 32'h5);
      chk("last table", {16'h0, rt}, 32'h7);
      cpu_u.xfer(1'b0, STATUS_OFS, 32'h0, q);
      chk("done bit", {31'h0, q[15]}, 32'h1);
      $display("test recalc done");
      final_report();
   end
endmodule // servo_request_contacts_tb_top
